// File: acq_command_register_one.sv
// command register one with its serial and acquisition control logic
`timescale 1ns/1ps
`default_nettype none
module acq_command_register_one (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_reset,
   // host word write port
   input wire logic i_wr_word,
   input wire logic [4:0] i_addr,
   input wire logic [acq_cmd_pkg::cmd_width-1:0] i_wdata,
   // calibration serial link
   output logic o_cal_memory_select,
   output logic o_serial_bit_out,
   output logic o_serial_clock,
   output logic o_cal_memory_clock,
   input wire logic i_cal_dac0_load,
   input wire logic i_cal_dac1_load,
   output logic [acq_cmd_pkg::cal_dac_bits-1:0] o_cal_dac0_value,
   output logic [acq_cmd_pkg::cal_dac_bits-1:0] o_cal_dac1_value,
   // triggers and acquisition status
   input wire logic i_start_strobe,
   input wire logic i_external_trigger_n,
   input wire logic i_bus_trigger,
   input wire logic i_progress_clear,
   input wire logic i_sequence_end,
   output logic o_counter_start,
   output logic o_acquisition_in_progress,
   // conversion and scanning
   input wire logic i_convert_request,
   input wire logic i_counter1_tick,
   input wire logic i_scan_interval_tick,
   input wire logic i_sequence_last,
   output logic o_convert,
   output logic o_memory_advance,
   output logic o_scan_clock_out,
   output logic o_scan_hold,
   output logic o_multi_channel,
   output logic o_wide_count
);
   import acq_cmd_pkg::*;
   typedef struct packed {
      logic [cmd_width-1:0] cmd;
      logic ext_trig_prev;
      acq_state_t acq;
      logic waiting_interval;
      logic convert;
      logic advance;
      logic start;
      logic mem_clock;
      logic scan_clock;
   } blk_state_t;
   blk_state_t state;
   blk_state_t next_state;
   logic cmd_write;
   logic sclk_rise;
   logic trig_event;
   logic armed;
   function automatic logic cmd_bit(input logic [cmd_width-1:0] r, input int pos);
      cmd_bit = r[pos];
   endfunction : cmd_bit
   assign cmd_write = i_wr_word && (i_addr == cmd_offset);
   // edge taken from the register bit, so a rewrite of the same value does nothing
   assign sclk_rise = cmd_write && i_wdata[bit_serial_clock]
      && !cmd_bit(state.cmd, bit_serial_clock); // see [R05]
   always_comb begin
      next_state = state;
      next_state.convert = 1'b0;
      next_state.advance = 1'b0;
      next_state.start = 1'b0;
      trig_event = 1'b0;
      armed = 1'b0;
      next_state.ext_trig_prev = i_external_trigger_n;
      if (cmd_write) begin
         next_state.cmd = i_wdata; // see [R01] [R20]
      end
      if (cmd_bit(state.cmd, bit_bus_trigger)) begin
         trig_event = i_bus_trigger; // see [R18]
      end else begin
         trig_event = i_start_strobe || (state.ext_trig_prev && !i_external_trigger_n); // see [R18]
      end
      if (cmd_bit(state.cmd, bit_rearm_lockout)) begin
         armed = (state.acq == acq_idle); // see [R11]
      end else begin
         armed = (state.acq != acq_running); // see [R11]
      end
      case (state.acq)
         acq_idle: begin
            if (trig_event && armed && cmd_bit(state.cmd, bit_acq_enable)) begin
               next_state.acq = acq_running; // see [R12]
               next_state.start = 1'b1;
               next_state.waiting_interval = 1'b0;
            end
         end
         acq_running: begin
            if (i_sequence_end) begin
               next_state.acq = acq_done;
            end
         end
         acq_done: begin
            if (trig_event && armed && cmd_bit(state.cmd, bit_acq_enable)) begin
               next_state.acq = acq_running; // see [R11] [R12]
               next_state.start = 1'b1;
               next_state.waiting_interval = 1'b0;
            end else if (i_progress_clear) begin
               next_state.acq = acq_idle; // see [R11]
            end
         end
         default: begin
            next_state.acq = acq_idle;
         end
      endcase
      if (state.acq == acq_running && !state.waiting_interval && !cmd_bit(state.cmd, bit_conv_inhibit)) begin
         next_state.convert = i_convert_request; // see [R10]
      end
      if (state.acq == acq_running && cmd_bit(state.cmd, bit_multi_channel)) begin
         if (cmd_bit(state.cmd, bit_seq_counter)) begin
            next_state.advance = i_counter1_tick; // see [R08]
         end else begin
            next_state.advance = state.convert; // see [R08]
         end
         // interval mode parks after the last entry until the next interval tick
         if (cmd_bit(state.cmd, bit_interval_scan)) begin
            if (next_state.advance && i_sequence_last) begin
               next_state.waiting_interval = 1'b1; // see [R15]
            end else if (i_scan_interval_tick) begin
               next_state.waiting_interval = 1'b0; // see [R15]
            end
         end else begin
            next_state.waiting_interval = 1'b0; // see [R15]
         end
      end else begin
         next_state.waiting_interval = 1'b0;
      end
      if (i_reset) begin
         // command bits are deliberately not cleared by reset
         next_state.acq = acq_idle;
         next_state.waiting_interval = 1'b0;
         next_state.convert = 1'b0;
         next_state.advance = 1'b0;
         next_state.start = 1'b0;
      end
      // both clock outputs leave a flop, so a write that changes two bits at once cannot glitch them
      next_state.mem_clock = cmd_bit(next_state.cmd, bit_serial_clock)
         && cmd_bit(next_state.cmd, bit_mem_select); // see [R06]
      next_state.scan_clock = cmd_bit(next_state.cmd, bit_multi_channel) && next_state.advance; // see [R14]
   end
   always_ff @(posedge i_clk_sys) begin
      state <= next_state;
   end
   cal_dac_shift u_cal_dac0 (
      .i_clk_sys(i_clk_sys),
      .i_shift(sclk_rise),
      .i_data(i_wdata[bit_serial_data]),
      .i_load(i_cal_dac0_load),
      .o_value(o_cal_dac0_value)
   ); // see [R07]
   cal_dac_shift u_cal_dac1 (
      .i_clk_sys(i_clk_sys),
      .i_shift(sclk_rise),
      .i_data(i_wdata[bit_serial_data]),
      .i_load(i_cal_dac1_load),
      .o_value(o_cal_dac1_value)
   ); // see [R07]
   assign o_cal_memory_select = cmd_bit(state.cmd, bit_mem_select); // see [R02]
   assign o_serial_bit_out = cmd_bit(state.cmd, bit_serial_data); // see [R04]
   assign o_serial_clock = cmd_bit(state.cmd, bit_serial_clock); // see [R05]
   assign o_cal_memory_clock = state.mem_clock; // see [R06]
   assign o_counter_start = state.start;
   assign o_acquisition_in_progress = (state.acq != acq_idle);
   assign o_convert = state.convert;
   assign o_memory_advance = state.advance;
   assign o_scan_clock_out = state.scan_clock; // see [R14]
   assign o_scan_hold = state.waiting_interval;
   assign o_multi_channel = cmd_bit(state.cmd, bit_multi_channel) && cmd_bit(state.cmd, bit_acq_enable); // see [R13]
   assign o_wide_count = cmd_bit(state.cmd, bit_wide_count); // see [R16]
endmodule : acq_command_register_one
`default_nettype wire

// File: acq_cmd_pkg.sv
// constants shared by the acquisition command register block
// What this block does, and what the host must do
// [R01] write-only 16-bit register, reset leaves it alone
// [R02] bit 15 drives calibration memory select
// [R03] host pulses serial clock before selecting memory
// [R04] bit 14 drives shared serial data line
// [R05] bit 13 rising edge clocks serial data
// [R06] memory ignores serial clock while deselected
// [R07] dac shifts always, output only on load
// [R08] bit 12 picks counter or per-conversion sequencing
// [R09] host writes zero to bits 11, 3-0
// [R10] bit 10 suppresses all conversions
// [R11] bit 9 locks rearm until progress cleared
// [R12] bit 8 lets triggers start counters
// [R13] bit 7 selects scanned or single channel, o_multi_channel only with bit 8 set
// [R14] scan clock output only while scanning
// [R15] bit 6 selects interval or continuous scanning
// [R16] bit 5 selects 32-bit chained counting
// [R17] host picks wide count above 65,536 conversions
// [R18] bit 4 takes triggers from board bus only
// [R19] host uses word writes only
// [R20] word write updates all bits together
package acq_cmd_pkg;
   localparam logic [4:0] cmd_offset = 5'h00;
   localparam int cmd_width = 16;
   localparam int bit_mem_select = 15;
   localparam int bit_serial_data = 14;
   localparam int bit_serial_clock = 13;
   localparam int bit_seq_counter = 12;
   localparam int bit_conv_inhibit = 10;
   localparam int bit_rearm_lockout = 9;
   localparam int bit_acq_enable = 8;
   localparam int bit_multi_channel = 7;
   localparam int bit_interval_scan = 6;
   localparam int bit_wide_count = 5;
   localparam int bit_bus_trigger = 4;
   localparam int cal_dac_bits = 12;
   localparam logic [cmd_width-1:0] cmd_init_value = 16'h0000;
   typedef enum logic [2:0] {
      acq_idle = 3'b001,
      acq_running = 3'b010,
      acq_done = 3'b100
   } acq_state_t;
endpackage : acq_cmd_pkg

// File: cal_dac_shift.sv
// serial shift path and load latch of one calibration dac
`timescale 1ns/1ps
`default_nettype none
module cal_dac_shift (
   // clock
   input wire logic i_clk_sys,
   // serial path
   input wire logic i_shift,
   input wire logic i_data,
   input wire logic i_load,
   // dac value
   output logic [acq_cmd_pkg::cal_dac_bits-1:0] o_value
);
   import acq_cmd_pkg::*;
   typedef struct packed {
      logic [cal_dac_bits-1:0] shift;
      logic [cal_dac_bits-1:0] value;
   } dac_state_t;
   dac_state_t state;
   dac_state_t next_state;
   // no reset: calibration values survive a board reset like the command bits
   always_comb begin
      next_state = state;
      if (i_shift) begin
         next_state.shift = {state.shift[cal_dac_bits-2:0], i_data}; // see [R07]
      end
      if (i_load) begin
         next_state.value = state.shift; // see [R07]
      end
   end
   always_ff @(posedge i_clk_sys) begin
      state <= next_state;
   end
   assign o_value = state.value;
endmodule : cal_dac_shift
`default_nettype wire

// File: acq_cmd_sva.sv
// assertion checker for command register one
`timescale 1ns/1ps
`default_nettype none
module acq_cmd_sva (
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic i_wr_word,
   input wire logic [4:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_convert_request,
   input wire logic i_bus_trigger,
   input wire logic o_cal_memory_select,
   input wire logic o_serial_bit_out,
   input wire logic o_serial_clock,
   input wire logic o_cal_memory_clock,
   input wire logic o_counter_start,
   input wire logic o_convert,
   input wire logic o_memory_advance,
   input wire logic o_scan_clock_out,
   input wire logic o_multi_channel,
   input wire logic o_wide_count
);
   logic [15:0] cmd;
   logic seen = 1'b0;
   wire logic wr = i_wr_word && i_addr == 5'h00;
   // shadow has no reset, since the register keeps its bits through reset
   always_ff @(posedge i_clk_sys) begin
      if (wr) begin
         cmd <= i_wdata;
         seen <= 1'b1;
      end
   end
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);
   property p_bits; wr |=> {o_cal_memory_select, o_serial_bit_out, o_serial_clock} == $past(i_wdata[15:13]); endproperty
   a_bits: assert property (p_bits) else $error("serial bits wrong");
   property p_keep; seen && !wr |=> $stable({o_cal_memory_select, o_serial_bit_out, o_wide_count}); endproperty
   a_keep: assert property (p_keep) else $error("bits moved");
   property p_mclk; seen |-> o_cal_memory_clock == (o_serial_clock && o_cal_memory_select); endproperty
   a_mclk: assert property (p_mclk) else $error("memory clock wrong");
   property p_mode; seen |-> o_wide_count == cmd[5] && o_multi_channel == (cmd[7] && cmd[8]); endproperty
   a_mode: assert property (p_mode) else $error("mode wrong");
   property p_inh; i_convert_request && cmd[10] |=> !o_convert; endproperty
   a_inh: assert property (p_inh) else $error("convert while inhibited");
   property p_en; !cmd[8] |=> !o_counter_start; endproperty
   a_en: assert property (p_en) else $error("start while disabled");
   property p_bus; cmd[4] && !i_bus_trigger |=> !o_counter_start; endproperty
   a_bus: assert property (p_bus) else $error("local trigger taken");
   property p_scan; seen |-> o_scan_clock_out == (o_memory_advance && cmd[7]); endproperty
   a_scan: assert property (p_scan) else $error("scan clock wrong");
endmodule : acq_cmd_sva
bind acq_command_register_one acq_cmd_sva i_sva (.*);
`default_nettype wire

// File: acq_command_register_one_tb.sv
// self-checking bench for command register one
`timescale 1ns/1ps
`default_nettype none
`define CMP(n, e, s) begin checked++; if ((s) !== (e)) begin n_fail++; $display("FAIL %s expected %h seen %h", n, e, s); end end
module acq_command_register_one_tb;
   logic i_clk_sys = 1'b0, i_reset = 1'b1, i_wr_word = 1'b0;
   logic [4:0] i_addr = 5'h00;
   logic [15:0] i_wdata = 16'h0000, d;
   logic [10:0] pin = 11'h080;
   logic [11:0] v;
   logic [71:0] t, q[$];
   int checked = 0, n_fail = 0, cyc = 0, tn = 0;
   wire logic i_cal_dac0_load, i_cal_dac1_load, i_start_strobe, i_external_trigger_n, i_bus_trigger, i_progress_clear;
   wire logic i_sequence_end, i_convert_request, i_counter1_tick, i_scan_interval_tick, i_sequence_last;
   logic o_cal_memory_select, o_serial_bit_out, o_serial_clock, o_cal_memory_clock, o_counter_start, o_convert;
   logic o_acquisition_in_progress, o_memory_advance, o_scan_clock_out, o_scan_hold, o_multi_channel, o_wide_count;
   logic [11:0] o_cal_dac0_value, o_cal_dac1_value;
   wire logic [35:0] obs = {o_cal_dac1_value, o_cal_dac0_value, o_cal_memory_select, o_serial_bit_out, o_serial_clock,
      o_cal_memory_clock, o_multi_channel, o_wide_count, o_scan_hold, o_scan_clock_out, o_counter_start,
      o_acquisition_in_progress, o_convert, o_memory_advance};
   // idle pattern keeps the active-low external trigger high
   assign {i_cal_dac0_load, i_cal_dac1_load, i_start_strobe, i_external_trigger_n, i_bus_trigger, i_progress_clear,
      i_sequence_end, i_convert_request, i_counter1_tick, i_scan_interval_tick, i_sequence_last} = pin;
   acq_command_register_one i_dut (.*);
   always #5 i_clk_sys = ~i_clk_sys;
   task automatic w(input logic [15:0] x, input logic [4:0] a = 5'h00);
      @(negedge i_clk_sys);
      i_addr = a;
      i_wdata = x;
      i_wr_word = 1'b1;
      @(negedge i_clk_sys);
      i_wr_word = 1'b0;
   endtask : w
   task automatic p(input logic [10:0] x);
      @(negedge i_clk_sys);
      pin = x ^ 11'h080;
      @(negedge i_clk_sys);
      pin = 11'h080;
   endtask : p
   // level drive for pins that must stand across several edges
   task automatic s(input logic [10:0] x);
      @(negedge i_clk_sys);
      pin = x ^ 11'h080;
   endtask : s
   // note lands before the edge that shows the result, so no race with the watcher
   task automatic ck(input logic [71:0] x);
      q.push_back(x);
      @(posedge i_clk_sys);
      #1;
   endtask : ck
   task automatic f(input logic [5:0] x);
      ck({36'h00000003f, 30'h0, x});
   endtask : f
   function automatic logic [35:0] ex(input logic [15:0] x);
      return {24'h0, x[15:13], x[13] & x[15], x[7] & x[8], x[5], 6'h0};
   endfunction : ex
   task automatic fin;
      tn++;
      $display("test %0d ends", tn);
   endtask : fin
   task automatic complete_run;
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : complete_run
   always @(posedge i_clk_sys) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         complete_run();
      end
      if (q.size() > 0) begin
         t = q.pop_front();
         `CMP("outputs", t[35:0], obs & t[71:36])
      end
   end
   initial begin
      void'($urandom(32'h356a));
      repeat (4) @(negedge i_clk_sys);
      i_reset = 1'b0;
      // one serial clock pulse readies the memory before any select
      w(16'h2000);
      w(16'h0000);
      for (int k = 0; k < 4; k++) begin
         d = 16'($urandom) & 16'hf7f0;
         w(d);
         ck({36'hfc0, ex(d)});
      end
      fin();
      w(~d, 5'h02);
      ck({36'hfc0, ex(d)});
      @(negedge i_clk_sys);
      i_reset = 1'b1;
      @(negedge i_clk_sys);
      i_reset = 1'b0;
      ck({36'hfc0, ex(d)});
      fin();
      v = 12'($urandom);
      for (int i = 11; i >= 0; i--) begin
         w({1'b0, v[i], 14'h0});
         w({1'b0, v[i], 14'h2000});
      end
      p(11'h600);
      ck({36'hffffff000, v, v, 12'h0});
      w(16'h4000);
      w(16'h6000);
      ck({36'hfffffffc0, {v, v, 12'h0} | ex(16'h6000)});
      fin();
      w(16'h0400);
      p(11'h100);
      f(6'h00);
      w(16'h0580);
      p(11'h100);
      f(6'h0c);
      p(11'h008);
      f(6'h04);
      w(16'h0180);
      p(11'h008);
      f(6'h06);
      f(6'h15);
      fin();
      w(16'h0380);
      p(11'h010);
      f(6'h04);
      p(11'h100);
      f(6'h04);
      p(11'h020);
      f(6'h00);
      p(11'h100);
      f(6'h0c);
      w(16'h0180);
      p(11'h010);
      f(6'h04);
      p(11'h100);
      f(6'h0c);
      fin();
      p(11'h010);
      p(11'h020);
      w(16'h0190);
      p(11'h100);
      f(6'h00);
      p(11'h080);
      f(6'h00);
      p(11'h040);
      f(6'h0c);
      p(11'h010);
      p(11'h020);
      // wide count chosen as for a run of more than 65,536 conversions
      w(16'h0120);
      ck({36'hfc0, ex(16'h0120)});
      p(11'h080);
      f(6'h0c);
      fin();
      w(16'h1180);
      p(11'h008);
      f(6'h06);
      f(6'h04);
      p(11'h004);
      f(6'h15);
      fin();
      w(16'h01c0);
      s(11'h009);
      s(11'h001);
      s(11'h000);
      f(6'h35);
      p(11'h008);
      f(6'h24);
      p(11'h002);
      f(6'h04);
      p(11'h008);
      f(6'h06);
      w(16'h0180);
      s(11'h009);
      s(11'h001);
      s(11'h000);
      f(6'h15);
      fin();
      // reset while running: sequencing stops, command bits survive
      @(negedge i_clk_sys);
      i_reset = 1'b1;
      @(negedge i_clk_sys);
      i_reset = 1'b0;
      ck({36'hfff, ex(16'h0180)});
      fin();
      complete_run();
   end
endmodule : acq_command_register_one_tb
`default_nettype wire
